// file: core/ssw_top.sv
// Purpose: Shorted switch watchdog; trips a breaker when zero crossings stop
// Assumes: All pins except SRST asynchronous to MCLK; sensing already squared to a level
// Notes:   Disable path overrides everything; trip latches until disable or reset
`default_nettype none

// Notes on behaviour
// - Crossing impulses on the line-to-transformer input keep the watchdog from expiring.
// - The sensed voltage goes through a crossing detector that strobes the watchdog.
// - With no impulses the watchdog expires and the trip output asserts.
// - Firing-pulse activity holds the watchdog disabled during welds.
// - The disable has top priority and keeps trip inactive without impulses.
// - The impulse-removal test input blocks impulses so the watchdog times out.
// - The disable test input disables the watchdog like present firing pulses, but does not set WELD_SEEN.
// - Impulse removal plus disable test keeps trip inactive.
// - Impulse removal alone with no firing pulses makes trip activate.
// - Trip contact polarity is a build choice, normally open or normally closed.
module ssw_top
#(
   parameter int unsigned WD_TIMEOUT = ssw_pkg::WD_TIMEOUT_CYC,
   parameter int unsigned FP_HOLD    = ssw_pkg::FP_HOLD_CYC,
   parameter logic        CONTACT_POL = ssw_pkg::POL_NORM_OPEN
)
(
   input  wire logic MCLK,
   input  wire logic SRST,
   input  wire logic LINE_SENSE,
   input  wire logic FIRING_PULSE_IN,
   input  wire logic IMPULSE_REMOVE_CONTACT,
   input  wire logic IMPULSE_REMOVE_CONTACT_ALT,
   input  wire logic DISABLE_TEST_CONTACT,
   output var  logic TRIP_OUT_PLUS,
   output var  logic TRIP_OUT_MINUS,
   output var  logic TRIP_ACTIVE,
   output var  logic VOLTAGE_SEEN,
   output var  logic WELD_SEEN
);
   import ssw_pkg::*;

   logic              sense_s;
   logic              fp_s;
   logic              rm_s;
   logic              rm_alt_s;
   logic              dis_s;
   logic              sense_q;
   logic              cross_pulse;
   logic              strobe;
   logic              fp_q;
   logic              fp_rise;
   logic              fp_idle;
   logic              disable_now;
   logic              wd_expired;
   logic              trip_d;
   ssw_state_type     state_q;
   ssw_state_type     state_d;

   // Every input pin except MCLK and SRST passes the three-stage filter
   ssw_sync u_sync_sense
   (
      .clk      (MCLK),
      .srst     (SRST),
      .async_in (LINE_SENSE),
      .sync_out (sense_s)
   );

   ssw_sync u_sync_fp
   (
      .clk      (MCLK),
      .srst     (SRST),
      .async_in (FIRING_PULSE_IN),
      .sync_out (fp_s)
   );

   // Either removal contact works, so automation can use its own pair
   ssw_sync u_sync_rm
   (
      .clk      (MCLK),
      .srst     (SRST),
      .async_in (IMPULSE_REMOVE_CONTACT),
      .sync_out (rm_s)
   );

   ssw_sync u_sync_rm_alt
   (
      .clk      (MCLK),
      .srst     (SRST),
      .async_in (IMPULSE_REMOVE_CONTACT_ALT),
      .sync_out (rm_alt_s)
   );

   ssw_sync u_sync_dis
   (
      .clk      (MCLK),
      .srst     (SRST),
      .async_in (DISABLE_TEST_CONTACT),
      .sync_out (dis_s)
   );

   // Edge history for crossing and firing detection
   always_ff @(posedge MCLK)
   begin
      if (SRST)
      begin
         sense_q <= 1'b0;
         fp_q    <= 1'b0;
      end
      else
      begin
         sense_q <= sense_s;
         fp_q    <= fp_s;
      end
   end

   // Both edges of the squared mains are crossings
   assign cross_pulse = sense_s ^ sense_q;
   // Removal contacts block the strobe from the watchdog
   assign strobe = cross_pulse && !(rm_s || rm_alt_s);
   assign fp_rise = fp_s && !fp_q;

   // Gate pulses are brief, so stretch them to cover a whole weld
   ssw_retrig #(.LOAD(FP_HOLD)) u_fp_hold
   (
      .clk     (MCLK),
      .srst    (SRST),
      .kick    (fp_rise),
      .hold    (fp_s),
      .expired (fp_idle)
   );

   // Test disable acts the same as firing activity
   assign disable_now = !fp_idle || dis_s;

   // Watchdog: crossings reload it; disable holds it reloaded
   ssw_retrig #(.LOAD(WD_TIMEOUT)) u_watchdog
   (
      .clk     (MCLK),
      .srst    (SRST),
      .kick    (strobe),
      .hold    (disable_now),
      .expired (wd_expired)
   );

   // Disable is checked first so it always wins over expiry
   always_comb
   begin
      state_d = state_q;
      unique case (state_q)
         WD_ARMED:
         begin
            if (disable_now)
               state_d = WD_DISABLED;
            else if (wd_expired)
               state_d = WD_TRIPPED;
         end
         WD_DISABLED:
         begin
            if (!disable_now)
               state_d = WD_ARMED;
         end
         WD_TRIPPED:
         begin
            if (disable_now)
               state_d = WD_DISABLED;
         end
         default:
            state_d = WD_ARMED;
      endcase
   end

   always_ff @(posedge MCLK)
   begin
      if (SRST)
         state_q <= WD_ARMED;
      else
         state_q <= state_d;
   end

   assign trip_d = (state_d == WD_TRIPPED);

   // Contact drive follows the build polarity
   always_ff @(posedge MCLK)
   begin
      if (SRST)
      begin
         TRIP_ACTIVE    <= TRIP_RST;
         TRIP_OUT_PLUS  <= TRIP_RST ^ CONTACT_POL;
         TRIP_OUT_MINUS <= !(TRIP_RST ^ CONTACT_POL);
      end
      else
      begin
         TRIP_ACTIVE    <= trip_d;
         TRIP_OUT_PLUS  <= trip_d ^ CONTACT_POL;
         TRIP_OUT_MINUS <= !(trip_d ^ CONTACT_POL);
      end
   end

   // Indicators for line voltage and weld activity
   always_ff @(posedge MCLK)
   begin
      if (SRST)
      begin
         VOLTAGE_SEEN <= 1'b0;
         WELD_SEEN    <= 1'b0;
      end
      else
      begin
         VOLTAGE_SEEN <= !wd_expired && !disable_now;
         WELD_SEEN    <= !fp_idle;
      end
   end
endmodule
`default_nettype wire

// file: core/ssw_pkg.sv
// Purpose: Shared constants for the shorted switch watchdog
// Assumes: MCLK at 40 MHz
// Notes:   Times are given in their own unit, cycle counts derived
`default_nettype none
package ssw_pkg;
   localparam int unsigned CLK_HZ          = 40_000_000;
   // Mains half period at 50 Hz is 10 ms; allow about three missing crossings
   localparam int unsigned WD_TIMEOUT_US   = 30_000;
   localparam int unsigned WD_TIMEOUT_CYC  = (WD_TIMEOUT_US * (CLK_HZ / 1_000_000));
   // Firing pulses are short gate pulses; hold the disable across the gaps
   localparam int unsigned FP_HOLD_US      = 20_000;
   localparam int unsigned FP_HOLD_CYC     = (FP_HOLD_US * (CLK_HZ / 1_000_000));
   localparam int unsigned CNT_W           = 24;
   localparam int unsigned SYNC_STAGES     = 3;
   // Trip contact polarity variants
   localparam logic        POL_NORM_OPEN   = 1'b0;
   localparam logic        POL_NORM_CLOSED = 1'b1;
   localparam logic        TRIP_RST        = 1'b0;

   typedef enum logic [1:0]
   {
      WD_ARMED    = 2'b00,
      WD_DISABLED = 2'b01,
      WD_TRIPPED  = 2'b10
   } ssw_state_type;
endpackage
`default_nettype wire

// file: core/ssw_sync.sv
// Purpose: Three-stage synchroniser with agreement filter
// Assumes: Input is asynchronous to clk
// Notes:   Output changes once stages two and three agree
`default_nettype none
module ssw_sync
(
   input  wire logic clk,
   input  wire logic srst,
   input  wire logic async_in,
   output var  logic sync_out
);
   import ssw_pkg::*;

   logic s1_q;
   logic s2_q;
   logic s3_q;

   // Stage one is read by stage two only
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         s3_q <= 1'b0;
      end
      else
      begin
         s1_q <= async_in;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // Accept a level only when two later stages agree
   always_ff @(posedge clk)
   begin
      if (srst)
         sync_out <= 1'b0;
      else if (s2_q == s3_q)
         sync_out <= s3_q;
   end
endmodule
`default_nettype wire

// file: core/ssw_retrig.sv
// Purpose: Retriggerable down counter, expires after a load count
// Assumes: kick is a one-cycle pulse
// Notes:   Used for the watchdog and for firing-pulse stretching
`default_nettype none
module ssw_retrig
#(
   parameter int unsigned LOAD = 16
)
(
   input  wire logic clk,
   input  wire logic srst,
   input  wire logic kick,
   input  wire logic hold,
   output var  logic expired
);
   import ssw_pkg::*;

   localparam logic [CNT_W-1:0] LOAD_V = CNT_W'(LOAD);
   logic [CNT_W-1:0] cnt_q;

   // Kick or hold reloads; otherwise count down to zero
   always_ff @(posedge clk)
   begin
      if (srst || kick || hold)
         cnt_q <= LOAD_V;
      else if (cnt_q != '0)
         cnt_q <= cnt_q - 1'b1;
   end

   always_ff @(posedge clk)
   begin
      if (srst || kick || hold)
         expired <= 1'b0;
      else
         expired <= (cnt_q == '0);
   end
endmodule
`default_nettype wire

// file: testbench/ssw_top_monitor.sv
// Purpose: Port checker bound to ssw_top
// Assumes: Counts as set on the instance
// Notes:   Ages cap at 999 cycles
`default_nettype none
module ssw_top_monitor
#(
   parameter int unsigned WD_TIMEOUT  = 50,
   parameter int unsigned FP_HOLD     = 20,
   parameter logic        CONTACT_POL = 1'b0
)
(
   input wire logic MCLK,
   input wire logic SRST,
   input wire logic LINE_SENSE,
   input wire logic FIRING_PULSE_IN,
   input wire logic IMPULSE_REMOVE_CONTACT,
   input wire logic IMPULSE_REMOVE_CONTACT_ALT,
   input wire logic DISABLE_TEST_CONTACT,
   input wire logic TRIP_OUT_PLUS,
   input wire logic TRIP_OUT_MINUS,
   input wire logic TRIP_ACTIVE,
   input wire logic VOLTAGE_SEEN,
   input wire logic WELD_SEEN
);
   timeunit 1ns;
   timeprecision 1ps;
   logic        line_q;
   int unsigned gap_q;
   int unsigned fire_q;
   wire logic   rm = IMPULSE_REMOVE_CONTACT || IMPULSE_REMOVE_CONTACT_ALT;
   wire logic   fire = FIRING_PULSE_IN || DISABLE_TEST_CONTACT;
   // Ages since unblocked crossing and since disable activity
   always_ff @(posedge MCLK)
   begin
      line_q <= LINE_SENSE;
      gap_q <= SRST || (LINE_SENSE != line_q && !rm) ? 0 : gap_q + 32'(gap_q < 999);
      fire_q <= SRST || fire ? 0 : fire_q + 32'(fire_q < 999);
   end
   default clocking cb @(posedge MCLK);
   endclocking
   default disable iff (SRST);
   // Eight cycles outlast the input synchroniser
   sequence s_held;
      DISABLE_TEST_CONTACT [*8];
   endsequence
   sequence s_fp_rise;
      $rose(FIRING_PULSE_IN) && !WELD_SEEN;
   endsequence
   a_minus_mirror: assert property (TRIP_OUT_MINUS == !TRIP_OUT_PLUS)
      else $error("minus not inverse");
   a_plus_pol: assert property ($stable(TRIP_ACTIVE)
      |-> TRIP_OUT_PLUS == (TRIP_ACTIVE ^ CONTACT_POL)) else $error("plus polarity");
   a_trip_early: assert property ($rose(TRIP_ACTIVE) |-> gap_q + 4 >= WD_TIMEOUT)
      else $error("early trip");
   a_trip_late: assert property (gap_q > WD_TIMEOUT + FP_HOLD + 40
      && fire_q > WD_TIMEOUT + FP_HOLD + 40 |-> TRIP_ACTIVE) else $error("no trip");
   a_dis_quiet: assert property (s_held |-> !TRIP_ACTIVE && !VOLTAGE_SEEN)
      else $error("trip while disabled");
   a_fire_hold: assert property (fire_q inside {[8:FP_HOLD]} |-> !TRIP_ACTIVE)
      else $error("trip in hold");
   a_weld_flag: assert property (s_fp_rise |-> ##[1:8] WELD_SEEN)
      else $error("weld flag missing");
   a_sync_lag: assert property (s_fp_rise |=> !WELD_SEEN)
      else $error("firing unsynchronised");
endmodule
bind ssw_top ssw_top_monitor #(.WD_TIMEOUT(WD_TIMEOUT), .FP_HOLD(FP_HOLD),
   .CONTACT_POL(CONTACT_POL)) u_mon (.*);
`default_nettype wire

// file: testbench/ssw_weld_partner.sv
// Purpose: Weld control, test switch and breaker
// Assumes: st is switch position, line on, weld on
// Notes:   A shorted switch freezes the sense line
`default_nettype none
module ssw_weld_partner
(
   input  wire logic       clk,
   input  wire logic       srst,
   input  wire logic [3:0] st,
   input  wire logic       ta,
   output var  logic       ls,
   output var  logic       fp,
   output var  logic       rm,
   output var  logic       ra,
   output var  logic       dt,
   output var  logic       brk
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [4:0] n = 5'h0;
   // Half period 20 cycles; gate pulses 3 of every 10
   // Only whole pulses, since the pin filter would swallow a one-cycle sliver
   always @(posedge clk)
   begin
      n <= n == 5'h13 ? 5'h0 : n + 5'h1;
      if (srst)
         ls <= 1'b0;
      else if (st[1] && n == 5'h0)
         ls <= !ls;
      fp <= !srst && n % 5'ha < 5'h3 && (n % 5'ha == 5'h0 ? st[0] : fp);
      brk <= !srst && (brk || ta);
   end
   // Switch: 1 no-trip test, 2 trip test, 3 disable only
   assign rm = st[3:2] == 2'h2;
   assign ra = st[3:2] == 2'h1;
   assign dt = st[2];
endmodule
`default_nettype wire

// file: testbench/tb.sv
// Purpose: Self-checking bench for ssw_top
// Assumes: Timeout 50 and hold 20 cycles
// Notes:   Trip latches, so expectation carries over
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic POL = ssw_pkg::POL_NORM_CLOSED;
   logic       clk = 1'b0;
   logic       srst = 1'b1;
   logic [3:0] st = 4'h2;
   logic       ls, fp, rm, ra, dt, brk, pl, mn, ta, vs, ws;
   logic       exp_q = 1'b0;
   int         miscompares = 0;
   int         checks = 0;
   logic [3:0] corner [7] = '{4'h2, 4'ha, 4'h6, 4'h0, 4'hc, 4'h1, 4'h2};
   always #12.5 clk = !clk;
   ssw_weld_partner u_far (.clk(clk), .srst(srst), .st(st), .ta(ta), .ls(ls),
      .fp(fp), .rm(rm), .ra(ra), .dt(dt), .brk(brk));
   ssw_top #(.WD_TIMEOUT(50), .FP_HOLD(20), .CONTACT_POL(POL)) DUT (.MCLK(clk),
      .SRST(srst), .LINE_SENSE(ls), .FIRING_PULSE_IN(fp), .IMPULSE_REMOVE_CONTACT(rm),
      .IMPULSE_REMOVE_CONTACT_ALT(ra), .DISABLE_TEST_CONTACT(dt), .TRIP_OUT_PLUS(pl),
      .TRIP_OUT_MINUS(mn), .TRIP_ACTIVE(ta), .VOLTAGE_SEEN(vs), .WELD_SEEN(ws));
   // Disable wins; dead or blocked line trips; else trip holds
   function automatic logic exp_trip(logic prev, logic [3:0] s);
      if (s[2] || s[0])
         return 1'b0;
      return s[3] || !s[1] ? 1'b1 : prev;
   endfunction
   task automatic check(input logic seen, input logic want);
      checks++;
      if (seen !== want)
      begin
         miscompares++;
         $display("mismatch at %0t seen %h expected %h", $time, seen, want);
      end
   endtask
   // Window covers hold, full timeout and sync delay
   task automatic step(input logic [3:0] s);
      @(posedge clk);
      st <= s;
      repeat (120) @(posedge clk);
      #1;
      exp_q = exp_trip(exp_q, s);
      check(ta, exp_q);
      check(pl, exp_q ^ POL);
      check(mn, !(exp_q ^ POL));
      check(vs, s[1] && !(s[3] || s[2] || s[0]));
      check(ws, s[0]);
   endtask
   task automatic do_reset;
      @(posedge clk);
      srst <= 1'b1;
      repeat (4) @(posedge clk);
      srst <= 1'b0;
      exp_q = 1'b0;
   endtask
   task automatic tally_and_finish;
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // Corners first, then a mid-run reset, then random steps
   initial
   begin
      void'($urandom(32'hf775));
      do_reset();
      foreach (corner[i])
         step(corner[i]);
      check(brk, 1'b1);
      do_reset();
      @(posedge clk);
      #1;
      check(ta, 1'b0);
      check(brk, 1'b0);
      repeat (12)
         step(4'($urandom() % 16));
      tally_and_finish();
   end
endmodule
`default_nettype wire
